// *** otpcl_pkg.sv ***
// Shared constants and types for the fuse configuration loader
`default_nettype none
package otpcl_pkg;
    localparam int FUSE_BITS = 70;
    // Common word bits
    localparam int POS_SEL_DEF = 0;
    localparam int POS_BANK = 1;
    // Field low positions, bank zero then bank one
    localparam int POS_GAIN_B0 = 33;
    localparam int POS_GAIN_B1 = 66;
    localparam int POS_CREEP_B0 = 31;
    localparam int POS_CREEP_B1 = 64;
    localparam int POS_MON_B0 = 29;
    localparam int POS_MON_B1 = 62;
    localparam int POS_CAL_B0 = 27;
    localparam int POS_CAL_B1 = 60;
    localparam int POS_LED_B0 = 24;
    localparam int POS_LED_B1 = 57;
    localparam int POS_PLEV_B0 = 2;
    localparam int POS_PLEV_B1 = 35;
    localparam int PLEV_BITS = 22;
    // Hard-coded defaults
    localparam logic [1:0] DEF_GAIN = 2'h3;
    localparam logic [1:0] DEF_CREEP = 2'h1;
    localparam logic [1:0] DEF_MON = 2'h2;
    localparam logic [1:0] DEF_CAL = 2'h1;
    localparam logic [2:0] DEF_LED = 3'h5;
    localparam logic [21:0] DEF_PLEV = 22'h06A6D4;
    // Serial load frame length and mode-sample settle count
    localparam logic [6:0] SHIFT_LEN = 7'h46;
    localparam logic [1:0] SYNC_SETTLE = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_READ = 3'b010,
        ST_LOAD = 3'b011,
        ST_RUN = 3'b100
    } otpcl_state_t;
endpackage
`default_nettype wire

// *** otpcl_fuse_store.sv ***
// Two-bank fuse cell array with registered read and burn port
`default_nettype none
`timescale 1ns/100ps
module otpcl_fuse_store
    import otpcl_pkg::*;
#(
    parameter int WIDTH = FUSE_BITS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic rd_en,
    input wire logic burn_en,
    input wire logic [WIDTH-1:0] burn_data,
    output logic [WIDTH-1:0] rd_data
);
    if (WIDTH != FUSE_BITS) begin : g_width_check
        $error("fuse width must match the word");
    end

    // Cells hold their state across resets; a burn can only set cells
    logic [WIDTH-1:0] cell_q = '0;
    logic [WIDTH-1:0] cell_d;
    logic [WIDTH-1:0] rd_q;
    logic [WIDTH-1:0] rd_d;

    always_comb begin
        cell_d = burn_en ? (cell_q | burn_data) : cell_q;
        rd_d = rd_en ? cell_q : rd_q;
    end

    always_ff @(posedge mclk) begin
        cell_q <= cell_d;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign rd_data = rd_q;
endmodule // otpcl_fuse_store
`default_nettype wire

// *** otpcl_loader.sv ***
// Power-up mode selection, fuse readout, test register and setting decode
//
// Contract
// - Two independent fuse banks are held, the bank choice bit picking which one is used.
// - At every power-up the whole fuse word is read and the active bank's settings applied.
// - Mode is sampled only at power-up: select low is normal, select high with direction low is programming.
// - Programming mode persists until the supply is removed.
// - A test write loads a register over the program pin and the device behaves per that register.
// - A burn through the program pin permanently sets fuse cells.
// - In programming mode the motor, calibration and indicator pulse outputs stay active.
// - Word bit 0 low selects hard-coded defaults, high selects fuse values.
// - Word bit 1 selects bank zero or one, default zero, shared by both banks.
// - Gain code 00 is 4, 01 and 10 are 16, 11 is 20, default 11.
// - Creep code picks 2.32, 7.43, 14.9 or 29.7 mA, default 01.
// - Motor code gives 100 to 800 imp/kWh default 10; calibration multiplier 8 to 64 default 01.
// - Indicator code gives 100 to 6400 imp/kWh for 000 to 110, default 101.
// - The 22-bit pulse level defaults to 6A6D4 and sets the internal fast pulse.
// - The fuse word is 70 bits and its top two bits are ignored.
`default_nettype none
`timescale 1ns/100ps
module otpcl_loader
    import otpcl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic power_up_mode_select,
    input wire logic direction_output_i,
    output logic direction_output_o,
    output logic direction_output_oe,
    input wire logic energy_reverse,
    input wire logic program_pin,
    input wire logic program_clock,
    input wire logic program_load,
    output logic program_pin_mode,
    output logic cfg_valid,
    output logic pulse_out_enable,
    output logic [1:0] gain_code,
    output logic [4:0] gain_value,
    output logic [1:0] creep_code,
    output logic [11:0] creep_thresh_10ua,
    output logic [1:0] motor_code,
    output logic [9:0] motor_rate,
    output logic [1:0] cal_code,
    output logic [6:0] cal_mult,
    output logic [2:0] led_code,
    output logic [12:0] led_rate,
    output logic [21:0] pulse_level
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [32:0] bank_slice(input logic [FUSE_BITS-1:0] w, input logic bank);
        bank_slice = bank ? w[POS_GAIN_B1+1:POS_PLEV_B1] : w[POS_GAIN_B0+1:POS_PLEV_B0];
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic clk_prev_q;
    logic load_prev_q;
    logic mode_s, dir_s, pin_s, pclk_s, pload_s;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            clk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else begin
            sync1_q <= {power_up_mode_select, direction_output_i, program_pin, program_clock, program_load};
            sync2_q <= sync1_q;
            clk_prev_q <= sync2_q[1];
            load_prev_q <= sync2_q[0];
        end
    end
    assign {mode_s, dir_s, pin_s, pclk_s, pload_s} = sync2_q;

    // ****************************************
    // Power-up sequence
    // ****************************************
    otpcl_state_t state_q, state_d;
    logic [1:0] settle_q, settle_d;
    logic mode_program_pin_q, mode_program_pin_d;
    logic [FUSE_BITS-1:0] fuse_word_q, fuse_word_d;
    logic fuse_rd_en;
    logic [FUSE_BITS-1:0] fuse_rd_data;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        mode_program_pin_d = mode_program_pin_q;
        fuse_word_d = fuse_word_q;
        fuse_rd_en = 1'b0;
        case (state_q)
            ST_IDLE: state_d = ST_SAMPLE;
            ST_SAMPLE: begin
                if (settle_q == SYNC_SETTLE) begin
                    mode_program_pin_d = mode_s && !dir_s;
                    state_d = ST_READ;
                end else begin
                    settle_d = settle_q + 2'h1;
                end
            end
            ST_READ: begin
                fuse_rd_en = 1'b1;
                state_d = ST_LOAD;
            end
            ST_LOAD: begin
                fuse_word_d = fuse_rd_data;
                state_d = ST_RUN;
            end
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            settle_q <= '0;
            mode_program_pin_q <= 1'b0;
            fuse_word_q <= '0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            mode_program_pin_q <= mode_program_pin_d;
            fuse_word_q <= fuse_word_d;
        end
    end

    // ****************************************
    // Serial test register and burn
    // ****************************************
    logic [FUSE_BITS-1:0] shift_q, shift_d, test_q, test_d;
    logic [6:0] shift_cnt_q, shift_cnt_d;
    logic test_valid_q, test_valid_d;
    logic clk_rise, commit, test_commit, burn_en;

    assign clk_rise = pclk_s && !clk_prev_q;
    assign commit = mode_program_pin_q && (state_q == ST_RUN) && pload_s && !load_prev_q
                    && (shift_cnt_q == SHIFT_LEN);
    assign test_commit = commit && !pin_s;
    assign burn_en = commit && pin_s;

    always_comb begin
        shift_d = shift_q;
        shift_cnt_d = shift_cnt_q;
        test_d = test_q;
        test_valid_d = test_valid_q;
        if (commit) begin
            shift_cnt_d = '0;
        end else if (mode_program_pin_q && (state_q == ST_RUN) && clk_rise) begin
            shift_d = {pin_s, shift_q[FUSE_BITS-1:1]};
            if (shift_cnt_q != SHIFT_LEN) shift_cnt_d = shift_cnt_q + 7'h01;
        end
        if (test_commit) begin
            test_d = shift_q;
            test_valid_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= '0;
            shift_cnt_q <= '0;
            test_q <= '0;
            test_valid_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            shift_cnt_q <= shift_cnt_d;
            test_q <= test_d;
            test_valid_q <= test_valid_d;
        end
    end

    otpcl_fuse_store #(.WIDTH(FUSE_BITS)) i_otpcl_fuse_store (
        .mclk(mclk),
        .reset_n(reset_n),
        .rd_en(fuse_rd_en),
        .burn_en(burn_en),
        .burn_data(shift_q),
        .rd_data(fuse_rd_data)
    );

    // ****************************************
    // Setting decode
    // ****************************************
    logic [FUSE_BITS-1:0] src_word;
    logic [32:0] fld;
    logic [1:0] dg, dc, dm, dk;
    logic [2:0] dl;
    logic [21:0] dp;
    logic [4:0] gv;
    logic [11:0] cv;
    logic [9:0] mv;
    logic [6:0] kv;
    logic [12:0] lv;

    always_comb begin
        src_word = (mode_program_pin_q && test_valid_q) ? test_q : fuse_word_q;
        fld = bank_slice(src_word, src_word[POS_BANK]);
        if (src_word[POS_SEL_DEF]) begin
            {dg, dc, dm, dk, dl, dp} = fld;
        end else begin
            {dg, dc, dm, dk, dl, dp} = {DEF_GAIN, DEF_CREEP, DEF_MON, DEF_CAL, DEF_LED, DEF_PLEV};
        end
        case (dg)
            2'h0: gv = 5'h04;
            2'h3: gv = 5'h14;
            default: gv = 5'h10;
        endcase
        case (dc)
            2'h0: cv = 12'h0E8;
            2'h1: cv = 12'h2E7;
            2'h2: cv = 12'h5D2;
            default: cv = 12'hB9A;
        endcase
        mv = 10'h064 << dm;
        kv = 7'h08 << dk;
        lv = (dl == 3'h7) ? 13'h0000 : (13'h0064 << dl);
    end

    // ****************************************
    // Registered settings
    // ****************************************
    logic [79:0] cfg_q, cfg_d;
    logic valid_q, valid_d;
    logic dir_q, dir_d;
    always_comb begin
        cfg_d = cfg_q;
        valid_d = valid_q;
        dir_d = dir_q;
        if (state_q == ST_RUN) begin
            cfg_d = {dg, gv, dc, cv, dm, mv, dk, kv, dl, lv, dp};
            valid_d = 1'b1;
            dir_d = energy_reverse;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= '0;
            valid_q <= 1'b0;
            dir_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            valid_q <= valid_d;
            dir_q <= dir_d;
        end
    end
    assign {gain_code, gain_value, creep_code, creep_thresh_10ua, motor_code, motor_rate,
            cal_code, cal_mult, led_code, led_rate, pulse_level} = cfg_q;
    assign cfg_valid = valid_q;
    assign pulse_out_enable = valid_q;
    assign program_pin_mode = mode_program_pin_q;
    assign direction_output_o = dir_q;
    assign direction_output_oe = valid_q;

    // ****************************************
    // Assertions
    // ****************************************
    AST_MODE_ONCE: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(mode_program_pin_q) |-> $past(state_q) == ST_SAMPLE && $past(mode_s) && !$past(dir_s))
        else $error("programming mode entered outside power-up sampling");
    AST_MODE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_RUN |=> mode_program_pin_q == $past(mode_program_pin_q))
        else $error("mode changed after power-up");
    AST_READOUT: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_READ |=> state_q == ST_LOAD ##1 state_q == ST_RUN ##1 valid_q)
        else $error("fuse readout sequence broken");
    AST_DEFAULT_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
        !src_word[POS_SEL_DEF] |-> dp == DEF_PLEV && dl == DEF_LED && dg == DEF_GAIN)
        else $error("defaults not used while source bit is low");
    AST_BANK_ONE: assert property (@(posedge mclk) disable iff (!reset_n)
        src_word[POS_SEL_DEF] && src_word[POS_BANK] |-> dp == src_word[56:35] && dg == src_word[67:66])
        else $error("bank one fields not selected");
    AST_GAIN: assert property (@(posedge mclk) disable iff (!reset_n)
        (gv == 5'h04) == (dg == 2'h0) && (gv == 5'h14) == (dg == 2'h3))
        else $error("gain decode wrong");
    AST_CREEP: assert property (@(posedge mclk) disable iff (!reset_n)
        dc == 2'h1 |-> cv == 12'h2E7)
        else $error("creep threshold decode wrong");
    AST_TEST_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
        test_commit |=> test_valid_q && test_q == $past(shift_q) && src_word == test_q)
        else $error("test register not applied");
    AST_BURN_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
        burn_en |-> mode_program_pin_q && shift_cnt_q == SHIFT_LEN)
        else $error("burn outside programming mode or short frame");
    AST_PULSES_ON: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_RUN && $past(state_q) == ST_RUN |-> pulse_out_enable)
        else $error("pulse outputs not enabled");
endmodule // otpcl_loader
`default_nettype wire

// *** otpcl_programmer.sv ***
// Behavioural meter programmer driving the serial programming pins
`timescale 1ns/100ps
`default_nettype none
module otpcl_programmer (
    input wire logic mclk,
    output logic program_pin,
    output logic program_clock,
    output logic program_load
);
    initial begin
        program_pin = 1'b0;
        program_clock = 1'b0;
        program_load = 1'b0;
    end
    // Build a word: settings source set, chosen bank filled, other bank zero
    function automatic logic [69:0] compose(input logic bank, input logic [32:0] f);
        logic [69:0] w;
        w = '0;
        w[0] = 1'b1;
        w[1] = bank;
        w[(bank ? 35 : 2) +: 33] = f;
        return w;
    endfunction
    // Shift n bits LSB first, then commit; burn picks the commit kind
    task automatic send(input logic [69:0] w, input int n, input logic burn);
        @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            program_pin <= w[i];
            repeat (4) @(posedge mclk);
            program_clock <= 1'b1;
            repeat (4) @(posedge mclk);
            program_clock <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        program_pin <= burn;
        repeat (4) @(posedge mclk);
        program_load <= 1'b1;
        repeat (4) @(posedge mclk);
        program_load <= 1'b0;
        repeat (4) @(posedge mclk);
        program_pin <= ~burn;
    endtask
endmodule // otpcl_programmer
`default_nettype wire

// *** tb_otpcl_loader.sv ***
// Self-checking bench for the fuse configuration loader
`timescale 1ns/100ps
`default_nettype none
module tb_otpcl_loader;
    import otpcl_pkg::*;
    logic mclk, reset_n, mode_sel, dir_i, dir_o, dir_oe, dir_drv, dir_val, energy_reverse;
    logic program_pin, program_clock, program_load, program_pin_mode, cfg_valid, pulse_out_enable;
    logic [1:0] gain_code, creep_code, motor_code, cal_code;
    logic [2:0] led_code;
    logic [4:0] gain_value;
    logic [11:0] creep_thresh_10ua;
    logic [9:0] motor_rate;
    logic [6:0] cal_mult;
    logic [12:0] led_rate;
    logic [21:0] pulse_level;
    logic [69:0] w, w0;
    int num_errors, total_checks;
    int gtab[4] = '{4, 16, 16, 20};
    int ctab[4] = '{232, 743, 1490, 2970};
    // Pin level: device drive first, else programmer drive, else pull-down
    assign dir_i = dir_oe ? dir_o : (dir_drv ? dir_val : 1'b0);
    otpcl_loader i_otpcl_loader (.mclk(mclk), .reset_n(reset_n), .power_up_mode_select(mode_sel),
        .direction_output_i(dir_i), .direction_output_o(dir_o), .direction_output_oe(dir_oe),
        .energy_reverse(energy_reverse), .program_pin(program_pin), .program_clock(program_clock),
        .program_load(program_load), .program_pin_mode(program_pin_mode), .cfg_valid(cfg_valid),
        .pulse_out_enable(pulse_out_enable), .gain_code(gain_code), .gain_value(gain_value),
        .creep_code(creep_code), .creep_thresh_10ua(creep_thresh_10ua), .motor_code(motor_code),
        .motor_rate(motor_rate), .cal_code(cal_code), .cal_mult(cal_mult), .led_code(led_code),
        .led_rate(led_rate), .pulse_level(pulse_level));
    otpcl_programmer i_otpcl_programmer (.mclk(mclk), .program_pin(program_pin),
        .program_clock(program_clock), .program_load(program_load));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic power_up(input logic ms, input logic dv);
        int n;
        @(posedge mclk);
        reset_n <= 1'b0;
        mode_sel <= ms;
        dir_drv <= 1'b1;
        dir_val <= dv;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        check(dir_oe, 0, "oe sampling");
        n = 0;
        while (cfg_valid !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (cfg_valid !== 1'b1) begin
            check(0, 1, "power-up stalled");
            end_of_test();
        end
        @(posedge mclk);
        dir_drv <= 1'b0;
    endtask
    // Expected settings worked out from the fuse or test word
    task automatic check_cfg(input logic [69:0] v, input logic pm);
        int b, g, c, m, k, l, p;
        logic er;
        b = v[1] ? 35 : 2;
        g = v[0] ? v[b + 31 +: 2] : DEF_GAIN;
        c = v[0] ? v[b + 29 +: 2] : DEF_CREEP;
        m = v[0] ? v[b + 27 +: 2] : DEF_MON;
        k = v[0] ? v[b + 25 +: 2] : DEF_CAL;
        l = v[0] ? v[b + 22 +: 3] : DEF_LED;
        p = v[0] ? v[b +: 22] : DEF_PLEV;
        er = 1'($urandom);
        @(posedge mclk);
        energy_reverse <= er;
        repeat (3) @(posedge mclk);
        #1;
        check(program_pin_mode, pm, "mode");
        check({cfg_valid, pulse_out_enable}, 3, "enables");
        check({dir_oe, dir_o}, {1'b1, er}, "direction");
        check({gain_code, gain_value}, {g[1:0], 5'(gtab[g])}, "gain");
        check({creep_code, creep_thresh_10ua}, {c[1:0], 12'(ctab[c])}, "creep");
        check({motor_code, motor_rate}, {m[1:0], 10'(100 << m)}, "motor");
        check({cal_code, cal_mult}, {k[1:0], 7'(8 << k)}, "cal");
        check({led_code, led_rate}, {l[2:0], 13'(l == 7 ? 0 : 100 << l)}, "led");
        check(pulse_level, p, "level");
    endtask
    initial begin
        reset_n = 1'b0;
        mode_sel = 1'b0;
        dir_drv = 1'b0;
        dir_val = 1'b0;
        energy_reverse = 1'b0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h874E95DC));
        power_up(1'b0, 1'b0);
        check_cfg('0, 1'b0);
        i_otpcl_programmer.send(i_otpcl_programmer.compose(1'b0, 33'($urandom)), 70, 1'b0);
        check_cfg('0, 1'b0);
        $display("test normal done");
        power_up(1'b1, 1'b1);
        check_cfg('0, 1'b0);
        $display("test direction high done");
        power_up(1'b1, 1'b0);
        check_cfg('0, 1'b1);
        mode_sel <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            w = i_otpcl_programmer.compose(i[0], {2'(i), 2'(i + 1), 2'(i + 2), 2'(i + 3), 3'(i), 22'($urandom)});
            w[69:68] = 2'($urandom);
            i_otpcl_programmer.send(w, 70, 1'b0);
            check_cfg(w, 1'b1);
        end
        w[0] = 1'b0;
        // Top bit set so a wrongly accepted short frame would turn the source bit on
        w[69] = 1'b1;
        i_otpcl_programmer.send(w, 70, 1'b0);
        check_cfg(w, 1'b1);
        i_otpcl_programmer.send(~w, 69, 1'b0);
        check_cfg(w, 1'b1);
        $display("test write done");
        w0 = i_otpcl_programmer.compose(1'b0, 33'($urandom));
        i_otpcl_programmer.send(w0, 70, 1'b1);
        power_up(1'b0, 1'b0);
        check_cfg(w0, 1'b0);
        power_up(1'b1, 1'b0);
        w = i_otpcl_programmer.compose(1'b1, 33'($urandom));
        i_otpcl_programmer.send(w, 70, 1'b1);
        power_up(1'b0, 1'b0);
        check_cfg(w0 | w, 1'b0);
        $display("test burn done");
        end_of_test();
    end
endmodule // tb_otpcl_loader
`default_nettype wire
